/* rtl/rhsp_host_port.sv */
// Purpose: host serial port of a radio module: uart, handshake and sidebands
// Assumes: rxd and cmd_sel come from pins; radio side is same-clock logic
// Notes: bytes taken from the host queue in a small buffer until the radio consumes them
module rhsp_host_port import rhsp_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // host pins
  input wire logic rxd,
  input wire logic cmd_sel,
  output logic txd,
  output logic cts_n,
  output logic reply_marker_out,
  output logic tx_drained_flag,
  output logic fault_alert_out,
  // radio side: bytes from host
  output logic host_valid,
  output logic [7:0] host_byte,
  output logic host_is_cmd,
  input wire logic host_ready,
  // radio side: bytes to host
  input wire logic out_valid,
  input wire logic [7:0] out_byte,
  input wire logic out_is_reply,
  output logic out_ready,
  // fault causes
  input wire logic [7:0] fault_event,
  input wire logic [7:0] fault_mask,
  input wire logic fault_cause_rd,
  output logic [7:0] fault_cause_reg
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rhsp_rx_e;

  // pin synchronisers
  logic [1:0] rxd_sync_ff, cmd_sync_ff;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxd_sync_ff <= 2'h3;
      cmd_sync_ff <= 2'h3;
    end else begin
      rxd_sync_ff <= {rxd_sync_ff[0], rxd};
      cmd_sync_ff <= {cmd_sync_ff[0], cmd_sel};
    end
  end
  wire logic rxd_s = rxd_sync_ff[1];
  wire logic cmd_s = cmd_sync_ff[1];

  // receiver
  rhsp_rx_e st_ff, nxt_st;
  logic [11:0] rcnt_ff, nxt_rcnt;
  logic [2:0] rbit_ff, nxt_rbit;
  logic [7:0] rsh_ff, nxt_rsh;
  logic rkind_ff, nxt_rkind;
  logic rdone;

  always_comb begin
    nxt_st = st_ff;
    nxt_rcnt = rcnt_ff;
    nxt_rbit = rbit_ff;
    nxt_rsh = rsh_ff;
    nxt_rkind = rkind_ff;
    rdone = 1'b0;
    case (st_ff)
      RX_IDLE: begin
        if (!rxd_s) begin
          nxt_st = RX_START;
          nxt_rcnt = HALF_CYC;
          nxt_rkind = cmd_s;
        end
      end
      RX_START: begin
        if (rcnt_ff != 12'h000) begin
          nxt_rcnt = rcnt_ff - 12'h001;
        end else if (rxd_s) begin
          nxt_st = RX_IDLE;
        end else begin
          nxt_st = RX_DATA;
          nxt_rcnt = BIT_CYC - 12'h001;
          nxt_rbit = 3'h0;
        end
      end
      RX_DATA: begin
        if (rcnt_ff != 12'h000) begin
          nxt_rcnt = rcnt_ff - 12'h001;
        end else begin
          nxt_rsh = {rxd_s, rsh_ff[7:1]};
          nxt_rcnt = BIT_CYC - 12'h001;
          nxt_rbit = rbit_ff + 3'h1;
          if (rbit_ff == BIT_LAST) begin
            nxt_st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (rcnt_ff != 12'h000) begin
          nxt_rcnt = rcnt_ff - 12'h001;
        end else begin
          nxt_st = RX_IDLE;
          rdone = rxd_s;
        end
      end
      default: nxt_st = RX_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= RX_IDLE;
      rcnt_ff <= 12'h000;
      rbit_ff <= 3'h0;
      rsh_ff <= 8'h00;
      rkind_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      rcnt_ff <= nxt_rcnt;
      rbit_ff <= nxt_rbit;
      rsh_ff <= nxt_rsh;
      rkind_ff <= nxt_rkind;
    end
  end

  // input buffer; one slot kept spare so a byte already in flight still fits
  logic [8:0] buf_mem [BUF_DEPTH];
  logic [2:0] wp_ff, nxt_wp, rp_ff, nxt_rp, cnt_ff, nxt_cnt;
  logic push, pop;

  assign push = rdone && (cnt_ff != 3'(BUF_DEPTH));
  assign pop = host_valid && host_ready;

  always_comb begin
    nxt_wp = push ? wp_ff + 3'h1 : wp_ff;
    nxt_rp = pop ? rp_ff + 3'h1 : rp_ff;
    nxt_cnt = cnt_ff + (push ? 3'h1 : 3'h0) - (pop ? 3'h1 : 3'h0);
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wp_ff <= 3'h0;
      rp_ff <= 3'h0;
      cnt_ff <= 3'h0;
    end else begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      buf_mem[wp_ff[1:0]] <= {rkind_ff, rsh_ff};
    end
  end

  assign host_valid = (cnt_ff != 3'h0);
  assign host_byte = buf_mem[rp_ff[1:0]][7:0];
  assign host_is_cmd = !buf_mem[rp_ff[1:0]][8];

  // sideband flags
  logic cts_n_ff, nxt_cts_n, drained_ff, nxt_drained;
  logic marker_ff, nxt_marker;
  logic [7:0] cause_ff, nxt_cause;
  logic alert_ff, nxt_alert;
  logic tx_start, tx_ready;

  assign tx_start = out_valid && tx_ready;
  assign out_ready = tx_ready;

  always_comb begin
    nxt_cts_n = (nxt_cnt >= 3'(BUF_DEPTH - 1));
    nxt_drained = (nxt_cnt == 3'h0);
    nxt_marker = tx_start ? !out_is_reply : marker_ff;
    // set wins over the read clear
    nxt_cause = (fault_cause_rd ? 8'h00 : cause_ff) | fault_event;
    nxt_alert = (|(fault_event & fault_mask)) || (alert_ff && !fault_cause_rd);
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cts_n_ff <= 1'b1;
      drained_ff <= 1'b1;
      marker_ff <= 1'b1;
      cause_ff <= CAUSE_RST;
      alert_ff <= 1'b0;
    end else begin
      cts_n_ff <= nxt_cts_n;
      drained_ff <= nxt_drained;
      marker_ff <= nxt_marker;
      cause_ff <= nxt_cause;
      alert_ff <= nxt_alert;
    end
  end

  assign cts_n = cts_n_ff;
  assign tx_drained_flag = drained_ff;
  assign reply_marker_out = marker_ff;
  assign fault_alert_out = alert_ff;
  assign fault_cause_reg = cause_ff;

  rhsp_uart_tx u_tx (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .start(tx_start),
    .data(out_byte),
    .ready(tx_ready),
    .txd(txd)
  );

  // checks
  property p_cts_full;
    @(posedge core_clk) disable iff (sys_rst) (cnt_ff >= 3'(BUF_DEPTH - 1)) |-> cts_n;
  endproperty
  a_cts_full: assert property (p_cts_full) else $error("cts not high near full");

  property p_drained;
    @(posedge core_clk) disable iff (sys_rst) tx_drained_flag == (cnt_ff == 3'h0);
  endproperty
  a_drained: assert property (p_drained) else $error("drained flag wrong");

  property p_alert_set;
    @(posedge core_clk) disable iff (sys_rst) |(fault_event & fault_mask) |=> fault_alert_out;
  endproperty
  a_alert_set: assert property (p_alert_set) else $error("alert missed");

  property p_alert_masked;
    @(posedge core_clk) disable iff (sys_rst)
      (!fault_alert_out && !(|(fault_event & fault_mask))) |=> !fault_alert_out;
  endproperty
  a_alert_masked: assert property (p_alert_masked) else $error("alert from masked cause");

  property p_alert_clr;
    @(posedge core_clk) disable iff (sys_rst)
      (fault_cause_rd && !(|(fault_event & fault_mask))) |=> !fault_alert_out;
  endproperty
  a_alert_clr: assert property (p_alert_clr) else $error("alert not cleared by read");

  property p_marker;
    @(posedge core_clk) disable iff (sys_rst) tx_start |=> reply_marker_out == !$past(out_is_reply);
  endproperty
  a_marker: assert property (p_marker) else $error("reply marker wrong");

  property p_tx_start_bit;
    @(posedge core_clk) disable iff (sys_rst) tx_start |=> !txd [*8];
  endproperty
  a_tx_start_bit: assert property (p_tx_start_bit) else $error("start bit missing");

  property p_push_kind;
    @(posedge core_clk) disable iff (sys_rst)
      (push && cnt_ff == 3'h0 && !pop) |=> host_is_cmd == !$past(rkind_ff);
  endproperty
  a_push_kind: assert property (p_push_kind) else $error("frame kind lost");

  property p_rx_push;
    @(posedge core_clk) disable iff (sys_rst) (rdone && cnt_ff == 3'h0) |=> host_valid;
  endproperty
  a_rx_push: assert property (p_rx_push) else $error("received byte dropped");

  c_rx_byte: cover property (@(posedge core_clk) disable iff (sys_rst) push);
  c_tx_reply: cover property (@(posedge core_clk) disable iff (sys_rst) tx_start && out_is_reply);
  c_alert_clear: cover property (@(posedge core_clk) disable iff (sys_rst) fault_alert_out ##1 !fault_alert_out);
endmodule : rhsp_host_port

/* rtl/rhsp_pkg.sv */
// Purpose: constants for the radio module host serial port
// Assumes: core_clk at 250 MHz, 8N1 framing
// Notes: baud divider and buffer depth are plain defaults
package rhsp_pkg;
  localparam int unsigned CLK_HZ = 250000000;
  localparam int unsigned BAUD_HZ = 115200;
  localparam logic [11:0] BIT_CYC = 12'(CLK_HZ / BAUD_HZ);
  localparam logic [11:0] HALF_CYC = 12'(CLK_HZ / BAUD_HZ / 2);
  localparam int unsigned BUF_DEPTH = 4;
  localparam int unsigned CAUSE_W = 8;
  localparam logic [7:0] CAUSE_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [2:0] BIT_LAST = 3'h7;
endpackage : rhsp_pkg

/* rtl/rhsp_uart_tx.sv */
// Purpose: 8N1 serializer for the transmit line
// Assumes: byte held stable while start is high
// Notes: ready is high whenever idle
module rhsp_uart_tx import rhsp_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // byte side
  input wire logic start,
  input wire logic [7:0] data,
  output logic ready,
  // line
  output logic txd
);
  logic [11:0] cnt_ff, nxt_cnt;
  logic [3:0] idx_ff, nxt_idx;
  logic [9:0] sh_ff, nxt_sh;
  logic busy_ff, nxt_busy;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_idx = idx_ff;
    nxt_sh = sh_ff;
    nxt_busy = busy_ff;
    if (!busy_ff) begin
      if (start) begin
        nxt_sh = {1'b1, data, 1'b0};
        nxt_busy = 1'b1;
        nxt_cnt = BIT_CYC - 12'h001;
        nxt_idx = 4'h0;
      end
    end else if (cnt_ff != 12'h000) begin
      nxt_cnt = cnt_ff - 12'h001;
    end else if (idx_ff == 4'h9) begin
      nxt_busy = 1'b0;
    end else begin
      nxt_sh = {1'b1, sh_ff[9:1]};
      nxt_idx = idx_ff + 4'h1;
      nxt_cnt = BIT_CYC - 12'h001;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff <= 12'h000;
      idx_ff <= 4'h0;
      sh_ff <= 10'h3ff;
      busy_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      idx_ff <= nxt_idx;
      sh_ff <= nxt_sh;
      busy_ff <= nxt_busy;
    end
  end

  assign ready = !busy_ff;
  assign txd = busy_ff ? sh_ff[0] : 1'b1;
endmodule : rhsp_uart_tx

/* test/rhsp_host_model.sv */
// Purpose: host microcontroller model on the uart pins
// Assumes: 8N1, BIT_CYC cycles a bit, line idle high
// Notes: waits for clear-to-send before each byte
module rhsp_host_model import rhsp_pkg::*; (
  // clock
  input wire logic core_clk,
  // pins from the port
  input wire logic txd,
  input wire logic cts_n,
  // pins to the port
  output logic rxd,
  output logic cmd_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rxd = 1'b1;
    cmd_sel = 1'b1;
  end
  task automatic send_byte(input logic [7:0] b, input logic c);
    while (cts_n !== 1'b0) @(posedge core_clk);
    // realign to one step after an edge, like every other stimulus
    @(posedge core_clk);
    #1;
    // kind settles ahead of the start bit so both synchronisers agree
    cmd_sel = c;
    repeat (4) @(posedge core_clk);
    #1;
    rxd = 1'b0;
    for (int i = 0; i < 10; i++) begin
      repeat (BIT_CYC) @(posedge core_clk);
      #1;
      rxd = (i < 8) ? b[i] : 1'b1;
    end
  endtask : send_byte
  task automatic recv_byte(output logic [7:0] b, output logic stop);
    @(negedge txd);
    repeat (HALF_CYC) @(posedge core_clk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CYC) @(posedge core_clk);
      #1;
      if (i < 8) b[i] = txd;
      else stop = txd;
    end
  endtask : recv_byte
endmodule : rhsp_host_model

/* test/tb_radio_module_host_serial_port.sv */
// Purpose: self-checking bench for the host serial port
// Assumes: 250 MHz clock, 115200 baud, 4-entry buffer
// Notes: air byte goes out while host bytes come in
module tb_radio_module_host_serial_port import rhsp_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic rxd, cmd_sel, txd, cts_n, reply_marker_out, tx_drained_flag;
  logic fault_alert_out, host_valid, host_is_cmd, out_ready;
  logic [7:0] host_byte, fault_cause_reg;
  logic host_ready = 1'b0;
  logic out_valid = 1'b0;
  logic out_is_reply = 1'b0;
  logic fault_cause_rd = 1'b0;
  logic [7:0] out_byte = 8'h00;
  logic [7:0] fault_event = 8'h00;
  logic [7:0] fault_mask = 8'h00;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  always #2 core_clk = ~core_clk;
  rhsp_host_port dut (.core_clk, .sys_rst, .rxd, .cmd_sel, .txd, .cts_n, .reply_marker_out,
    .tx_drained_flag, .fault_alert_out, .host_valid, .host_byte, .host_is_cmd, .host_ready,
    .out_valid, .out_byte, .out_is_reply, .out_ready, .fault_event, .fault_mask,
    .fault_cause_rd, .fault_cause_reg);
  rhsp_host_model host (.core_clk, .txd, .cts_n, .rxd, .cmd_sel);
  task automatic complete_run();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  // ceiling covers three host bytes and one reply byte with margin
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 95000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic send_out(input logic [7:0] d, input logic r);
    out_byte = d;
    out_is_reply = r;
    out_valid = 1'b1;
    while (out_ready !== 1'b1) tick(1);
    tick(1);
    out_valid = 1'b0;
  endtask : send_out
  task automatic pop(input logic [7:0] e, input logic c);
    chk({7'h0, host_valid}, 8'h01);
    chk(host_byte, e);
    chk({7'h0, host_is_cmd}, {7'h0, c});
    host_ready = 1'b1;
    tick(1);
    host_ready = 1'b0;
    tick(2);
  endtask : pop
  task automatic t_reset();
    chk({1'b0, txd, cts_n, tx_drained_flag, reply_marker_out, fault_alert_out, host_valid, out_ready},
      8'h79);
    chk(fault_cause_reg, 8'h00);
    sys_rst = 1'b0;
    tick(2);
    chk({7'h0, cts_n}, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_fault();
    fault_mask = 8'h01;
    fault_event = 8'h02;
    tick(1);
    fault_event = 8'h00;
    chk({7'h0, fault_alert_out}, 8'h00);
    chk(fault_cause_reg, 8'h02);
    fault_event = 8'h01;
    tick(1);
    fault_event = 8'h00;
    chk({7'h0, fault_alert_out}, 8'h01);
    chk(fault_cause_reg, 8'h03);
    fault_cause_rd = 1'b1;
    tick(1);
    fault_cause_rd = 1'b0;
    chk({7'h0, fault_alert_out}, 8'h00);
    chk(fault_cause_reg, 8'h00);
    $display("test fault done");
  endtask : t_fault
  task automatic t_stream();
    logic [7:0] b;
    logic stop;
    fork
      begin
        host.send_byte(8'ha5, 1'b0);
        chk({7'h0, tx_drained_flag}, 8'h00);
        host.send_byte(8'h3c, 1'b1);
        host.send_byte(8'hc3, 1'b1);
      end
      begin
        // the host receiver must already wait when the start edge is launched
        fork
          send_out(8'h5a, 1'b0);
          host.recv_byte(b, stop);
        join
        chk(b, 8'h5a);
        chk({6'h0, reply_marker_out, stop}, 8'h03);
      end
    join
    tick(4);
    chk({7'h0, cts_n}, 8'h01);
    pop(8'ha5, 1'b1);
    chk({7'h0, cts_n}, 8'h00);
    pop(8'h3c, 1'b0);
    pop(8'hc3, 1'b0);
    chk({6'h0, tx_drained_flag, host_valid}, 8'h02);
    $display("test stream done");
  endtask : t_stream
  task automatic t_reply();
    logic [7:0] b;
    logic stop;
    fork
      send_out(8'h96, 1'b1);
      host.recv_byte(b, stop);
    join
    chk(b, 8'h96);
    chk({6'h0, reply_marker_out, stop}, 8'h01);
    $display("test reply done");
  endtask : t_reply
  initial begin
    tick(3);
    t_reset();
    t_fault();
    t_stream();
    t_reply();
    complete_run();
  end
endmodule : tb_radio_module_host_serial_port
